/* File: design/overcurrent_flag_output_logic.sv */
// overcurrent fault flag: window counting, hold mode, enable and registers
//
// Behaviour
// RULE_01: fault pin is open-drain, pulled low while over range, else released.
// RULE_02: exactly two output modes, transparent or hold, picked by hold pin.
// RULE_03: hold pin low means transparent: fault follows the condition.
// RULE_04: hold pin high means hold mode.
// RULE_05: transparent: assert on detection, release after one clean window.
// RULE_06: hold mode keeps the fault low after the input drops back.
// RULE_07: host clears a held fault by holding hold pin low 20 us or more.
// RULE_08: on hold pin low, release only if input is below threshold.
// RULE_09: host may raise the hold pin again to re-arm hold mode.
// RULE_10: enable low means low-power disabled, enable high means operating.
// RULE_11: enable falling reaches the disabled state after about 20 us.
// RULE_12: enable rising resumes normal operation after about 300 us.
// RULE_13: consecutive window counter clears when disabled, restarts from zero.
// RULE_14: free-running 10 us window yields one averaged over-threshold result.
// RULE_15: fault after 1, 5 or 10 consecutive over windows; clean window resets.
// RULE_16: response pin: floating 10 us, ground 50 us, supply 100 us.
// RULE_17: hold pin low time is judged by counting comparison windows.
// RULE_18: while disabled the fault is released and hold pin ignored.
`timescale 1ns/1ps
`include "ocp_map.svh"

module overcurrent_flag_output_logic
#(
  parameter int unsigned WAKE_CYCLES = `RESUME_US * `CLK_MHZ
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic above_limit,
  input wire logic hold_select,
  input wire logic enable,
  input wire logic [1:0] response_select,
  output logic fault_pin_out,
  output logic fault_pin_oe_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // pin synchronisers
  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_s1;
  logic [`PIN_COUNT-1:0] pin_s2;
  logic [`PIN_COUNT-1:0] pin_s3;
  logic [`PIN_COUNT-1:0] pin;

  assign pin_raw = {enable, hold_select, above_limit, response_select};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end

      // a change is accepted only once the last two stages agree
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          pin[gi] <= 1'b0;
        else if (clk_en && (pin_s2[gi] == pin_s3[gi]))
          pin[gi] <= pin_s3[gi];
      end
    end
  endgenerate

  logic hold_mode;
  logic enable_in;
  ocp_pkg::resp_code_t resp_code;

  assign hold_mode = pin[`PIN_HOLD]; // RULE_02 RULE_04
  assign enable_in = pin[`PIN_ENABLE];
  assign resp_code = pin[`PIN_RESP_HI:`PIN_RESP_LO];

  // comparison window
  window_if win ();

  assign win.clk_en = clk_en;
  assign win.sample = pin[`PIN_ABOVE];

  window_timebase u_window
  (
    .core_clk(core_clk),
    .rst(rst),
    .win(win)
  );

  // power state
  ocp_pkg::power_state_t pwr;
  ocp_pkg::power_state_t next_pwr;
  logic [`WAKE_CNT_W-1:0] pwr_cnt;
  logic operating;
  logic pwr_done;
  logic enter_off;
  logic enter_on;

  assign operating = (pwr == ocp_pkg::pwr_on) || (pwr == ocp_pkg::pwr_sleeping);

  always_comb
  begin
    pwr_done = 1'b0;
    case (pwr)
      ocp_pkg::pwr_waking:
        pwr_done = pwr_cnt >= `WAKE_CNT_W'(WAKE_CYCLES - 1); // RULE_12
      ocp_pkg::pwr_sleeping:
        pwr_done = pwr_cnt >= `WAKE_CNT_W'(`ENTER_CYCLES - 1); // RULE_11
      default:
        pwr_done = 1'b0;
    endcase
  end

  always_comb
  begin
    next_pwr = pwr;
    case (pwr)
      ocp_pkg::pwr_off:
        if (enable_in)
          next_pwr = ocp_pkg::pwr_waking;
      ocp_pkg::pwr_waking:
        if (!enable_in)
          next_pwr = ocp_pkg::pwr_off;
        else if (pwr_done)
          next_pwr = ocp_pkg::pwr_on;
      ocp_pkg::pwr_on:
        if (!enable_in)
          next_pwr = ocp_pkg::pwr_sleeping;
      ocp_pkg::pwr_sleeping:
        if (enable_in)
          next_pwr = ocp_pkg::pwr_on;
        else if (pwr_done)
          next_pwr = ocp_pkg::pwr_off;
      default:
        next_pwr = ocp_pkg::pwr_off;
    endcase
  end

  assign enter_off = (pwr == ocp_pkg::pwr_sleeping) &&
    (next_pwr == ocp_pkg::pwr_off);
  assign enter_on = (pwr == ocp_pkg::pwr_waking) &&
    (next_pwr == ocp_pkg::pwr_on);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pwr <= ocp_pkg::pwr_off;
    else if (clk_en)
      pwr <= next_pwr; // RULE_10
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pwr_cnt <= '0;
    else if (clk_en)
    begin
      if (next_pwr != pwr)
        pwr_cnt <= '0;
      else if (!pwr_done)
        pwr_cnt <= pwr_cnt + `WAKE_CNT_W'(1);
    end
  end

  // consecutive over-threshold windows
  logic [`OVER_CNT_W-1:0] need;
  logic [`OVER_CNT_W-1:0] over_cnt;
  logic [`OVER_CNT_W-1:0] over_inc;
  logic trigger;

  always_comb
  begin
    case (resp_code)
      `RESP_GND: need = `NEED_GND; // RULE_16
      `RESP_SUPPLY: need = `NEED_SUPPLY;
      default: need = `NEED_FLOAT;
    endcase
  end

  assign over_inc = over_cnt + `OVER_CNT_W'(1);
  assign trigger = operating && win.window_end && win.window_over &&
    (over_inc >= need); // RULE_15

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      over_cnt <= '0;
    else if (clk_en)
    begin
      if (!operating)
        over_cnt <= '0; // RULE_13
      else if (win.window_end)
      begin
        if (!win.window_over)
          over_cnt <= '0; // RULE_15
        else if (over_inc < need)
          over_cnt <= over_inc;
      end
    end
  end

  // hold pin low time, measured in whole windows
  logic [1:0] hold_low_windows;
  logic hold_clear_ok;

  // the clearing window end counts as the last one of the low run, so any
  // low pulse that spans the clear time is honoured whatever the window phase
  assign hold_clear_ok =
    (hold_low_windows + 2'(1)) >= 2'(`HOLD_CLEAR_WINDOWS);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hold_low_windows <= '0;
    else if (clk_en)
    begin
      if (hold_mode || !operating)
        hold_low_windows <= '0;
      else if (win.window_end && !hold_clear_ok)
        hold_low_windows <= hold_low_windows + 2'(1); // RULE_17
    end
  end

  // fault flag; the pin driver state doubles as the flag itself
  logic fault;
  logic held;
  logic set_fault;
  logic clr_fault;

  assign fault = !fault_pin_oe_n;
  assign set_fault = trigger && !fault;
  // a held fault needs the hold pin low long enough and a clean window
  assign clr_fault = fault && (!operating ||
    (win.window_end && !win.window_over && !hold_mode &&
    (!held || hold_clear_ok))); // RULE_03 RULE_05 RULE_06 RULE_08 RULE_18

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fault_pin_oe_n <= 1'b1;
    else if (clk_en)
    begin
      if (clr_fault)
        fault_pin_oe_n <= 1'b1; // RULE_01
      else if (set_fault)
        fault_pin_oe_n <= 1'b0; // RULE_01
    end
  end

  // the pin is only ever pulled low, never driven high
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fault_pin_out <= 1'b0;
    else if (clk_en)
      fault_pin_out <= 1'b0;
  end

  // a fault is held once hold mode is seen while it stands
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      held <= 1'b0;
    else if (clk_en)
    begin
      if (clr_fault || !operating)
        held <= 1'b0;
      else if ((fault || set_fault) && hold_mode)
        held <= 1'b1; // RULE_06
    end
  end

  // registers
  logic [`EV_COUNT-1:0] status;
  logic [`EV_COUNT-1:0] mask;
  logic [`EV_COUNT-1:0] events;
  logic [31:0] state_word;
  logic [31:0] rd_value;

  assign events[`EV_ASSERT] = set_fault;
  assign events[`EV_RELEASE] = clr_fault;
  assign events[`EV_SLEEP] = enter_off;
  assign events[`EV_WAKE] = enter_on;

  always_comb
  begin
    state_word = '0;
    state_word[`ST_FAULT] = fault;
    state_word[`ST_HOLD] = hold_mode;
    state_word[`ST_ACTIVE] = operating;
    state_word[`ST_HELD] = held;
    state_word[`ST_COUNT_LO +: `OVER_CNT_W] = over_cnt;
    state_word[`ST_RESP_LO +: 2] = resp_code;
  end

  always_comb
  begin
    case (reg_addr)
      `REG_STATUS: rd_value = {{(32 - `EV_COUNT){1'b0}}, status};
      `REG_MASK: rd_value = {{(32 - `EV_COUNT){1'b0}}, mask};
      `REG_STATE: rd_value = state_word;
      default: rd_value = '0;
    endcase
  end

  // an event in the clearing cycle survives: set wins over write-one-clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= '0;
    else if (clk_en)
    begin
      if (reg_wr && (reg_addr == `REG_STATUS))
        status <= (status & ~reg_wdata[`EV_COUNT-1:0]) | events;
      else
        status <= status | events;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask <= '0;
    else if (clk_en && reg_wr && (reg_addr == `REG_MASK))
      mask <= reg_wdata[`EV_COUNT-1:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_value : '0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(status & mask);
  end

endmodule // overcurrent_flag_output_logic

/* File: include/ocp_map.svh */
// constants of the overcurrent flag block: timing, codes and register map
`ifndef OCP_MAP_SVH
`define OCP_MAP_SVH

`define CLK_MHZ 50
`define WINDOW_US 10
`define WINDOW_CYCLES (`WINDOW_US * `CLK_MHZ)
`define ENTER_US 20
`define ENTER_CYCLES (`ENTER_US * `CLK_MHZ)
`define RESUME_US 300
`define HOLD_CLEAR_US 20
`define HOLD_CLEAR_WINDOWS (`HOLD_CLEAR_US / `WINDOW_US)

`define WIN_CNT_W 9
`define OVER_CNT_W 4
`define WAKE_CNT_W 16

`define RESP_FLOAT 2'h0
`define RESP_GND 2'h1
`define RESP_SUPPLY 2'h2
`define NEED_FLOAT 4'h1
`define NEED_GND 4'h5
`define NEED_SUPPLY 4'ha

`define PIN_RESP_LO 0
`define PIN_RESP_HI 1
`define PIN_ABOVE 2
`define PIN_HOLD 3
`define PIN_ENABLE 4
`define PIN_COUNT 5

`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_STATE 8'h08

`define EV_ASSERT 0
`define EV_RELEASE 1
`define EV_SLEEP 2
`define EV_WAKE 3
`define EV_COUNT 4

`define ST_FAULT 0
`define ST_HOLD 1
`define ST_ACTIVE 2
`define ST_HELD 3
`define ST_COUNT_LO 4
`define ST_RESP_LO 8

`endif

/* File: include/ocp_pkg.sv */
// types shared by the overcurrent flag block
package ocp_pkg;

  typedef enum logic [1:0]
  {
    pwr_off,
    pwr_waking,
    pwr_on,
    pwr_sleeping
  } power_state_t;

  typedef logic [1:0] resp_code_t;

endpackage

/* File: include/window_if.sv */
// carrier between the comparison window timer and the flag logic
`timescale 1ns/1ps
interface window_if;
  logic clk_en;
  logic sample;
  logic window_end;
  logic window_over;

  modport timer
  (
    input clk_en,
    input sample,
    output window_end,
    output window_over
  );

  modport user
  (
    output clk_en,
    output sample,
    input window_end,
    input window_over
  );
endinterface

/* File: design/window_timebase.sv */
// free-running comparison window with averaging of the sensed sample
`timescale 1ns/1ps
`include "ocp_map.svh"

module window_timebase
(
  input wire logic core_clk,
  input wire logic rst,
  window_if.timer win
);

  logic [`WIN_CNT_W-1:0] phase;
  logic [`WIN_CNT_W-1:0] above_acc;
  logic last;
  logic [`WIN_CNT_W-1:0] total;

  assign last = (phase == `WIN_CNT_W'(`WINDOW_CYCLES - 1));
  assign total = above_acc + `WIN_CNT_W'(win.sample);

  // the window runs on regardless of enable, as the analog side does
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      phase <= '0;
    else if (win.clk_en)
      phase <= last ? '0 : phase + `WIN_CNT_W'(1);
  end

  // averaging: the window is over when most of its samples were above
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      above_acc <= '0;
    else if (win.clk_en)
      above_acc <= last ? '0 : total;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      win.window_end <= 1'b0;
      win.window_over <= 1'b0;
    end
    else if (win.clk_en)
    begin
      win.window_end <= last;
      if (last)
        win.window_over <= total > `WIN_CNT_W'(`WINDOW_CYCLES / 2); // RULE_14
    end
  end

endmodule // window_timebase

/* File: verification/ocp_flag_props.sv */
// port-level assertions for the overcurrent fault flag block
`timescale 1ns/1ps
module ocp_flag_props
#(
  parameter int unsigned WAKE_CYCLES = 20
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic above_limit,
  input wire logic hold_select,
  input wire logic enable,
  input wire logic [1:0] response_select,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [15:0] hi_run, lo_run, off_run, on_run, hl_run, held_run;
  logic held_flag;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  function automatic logic [15:0] up(input logic [15:0] v);
    return v + {15'h0, v != 16'hffff};
  endfunction
  // raw pin run lengths, saturating so that long idles never wrap
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hi_run <= 16'h0;
      lo_run <= 16'h0;
      off_run <= 16'h0;
      on_run <= 16'h0;
      hl_run <= 16'h0;
      held_run <= 16'h0;
      held_flag <= 1'b0;
    end
    else
    begin
      hi_run <= above_limit ? up(hi_run) : 16'h0;
      lo_run <= above_limit ? 16'h0 : up(lo_run);
      off_run <= enable ? 16'h0 : up(off_run);
      on_run <= enable ? up(on_run) : 16'h0;
      hl_run <= hold_select ? 16'h0 : up(hl_run);
      held_run <= (hold_select && !fault_pin_oe_n) ? up(held_run) : 16'h0;
      held_flag <= !fault_pin_oe_n && (held_flag || held_run > 16'd6);
    end
  end
  a_drain_data_low: assert property (fault_pin_out == 1'b0)
    else $error("fault pin data not low");
  a_fall_needs_over: assert property ($fell(fault_pin_oe_n) |->
    lo_run < 16'd260) else $error("fault without over window");
  a_gnd_five_windows: assert property ($fell(fault_pin_oe_n) &&
    response_select == 2'h1 |-> hi_run > 16'd2200)
    else $error("fault before five windows");
  a_supply_ten_windows: assert property ($fell(fault_pin_oe_n) &&
    response_select == 2'h2 |-> hi_run > 16'd4700)
    else $error("fault before ten windows");
  a_release_needs_clean: assert property ($rose(fault_pin_oe_n) &&
    off_run == 16'h0 |-> hi_run < 16'd520)
    else $error("release while input over");
  a_held_stays_low: assert property (held_run > 16'd6 &&
    off_run < 16'd900 |=> !fault_pin_oe_n) else $error("held fault lost");
  a_clean_releases: assert property (lo_run > 16'd1020 &&
    hl_run > 16'd1020 |-> fault_pin_oe_n) else $error("fault not released");
  a_off_released: assert property (off_run > 16'd1100 |->
    fault_pin_oe_n [*2]) else $error("fault while disabled");
  a_sleep_quiet: assert property ($fell(fault_pin_oe_n) |->
    off_run < 16'd1010) else $error("fault after entering off");
  a_wake_quiet: assert property ($fell(fault_pin_oe_n) && enable |->
    on_run > WAKE_CYCLES) else $error("fault while waking");
  a_hold_clear_time: assert property ($rose(fault_pin_oe_n) &&
    held_flag && off_run == 16'h0 |-> hl_run > 16'd500)
    else $error("held fault cleared too soon");
  a_rdata_after_read: assert property (reg_rdata != 32'h0 |->
    $past(reg_rd)) else $error("read data without read");
endmodule // ocp_flag_props

bind overcurrent_flag_output_logic ocp_flag_props
  #(.WAKE_CYCLES(WAKE_CYCLES)) i_props (.core_clk(core_clk), .rst(rst),
  .above_limit(above_limit), .hold_select(hold_select), .enable(enable),
  .response_select(response_select), .fault_pin_out(fault_pin_out),
  .fault_pin_oe_n(fault_pin_oe_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* File: verification/host_ctrl_model.sv */
// host controller model driving the hold-mode pin
`timescale 1ns/1ps
module host_ctrl_model
(
  input wire logic core_clk,
  input wire logic arm,
  input wire logic clear_go,
  input wire logic [15:0] clear_len,
  output logic hold_select
);
  logic [15:0] low_left;
  initial
  begin
    hold_select = 1'b0;
    low_left = 16'h0;
  end
  // a short clear_len is only ever commanded to provoke a refused clear
  always @(posedge core_clk)
  begin
    if (clear_go)
      low_left <= clear_len;
    else if (low_left != 16'h0)
      low_left <= low_left - 16'h1;
    hold_select <= arm && !clear_go && low_left <= 16'h1;
  end
endmodule // host_ctrl_model

/* File: verification/tb.sv */
// self-checking bench for the overcurrent fault flag block
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic above_limit = 1'b0;
  logic enable = 1'b1;
  logic [1:0] response_select = 2'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic arm = 1'b0;
  logic clear_go = 1'b0;
  logic [15:0] clear_len = 16'h0;
  logic hold_select, fault_pin_out, fault_pin_oe_n, irq, fault_wire;
  logic [31:0] reg_rdata, rv;
  int fails = 0;
  int check_count = 0;
  always #10 core_clk = ~core_clk;
  // pull-up holds the line high whenever the pin is not driven
  assign fault_wire = fault_pin_oe_n ? 1'b1 : fault_pin_out;
  overcurrent_flag_output_logic #(.WAKE_CYCLES(20)) i_dut (
    .core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .above_limit(above_limit), .hold_select(hold_select), .enable(enable),
    .response_select(response_select), .fault_pin_out(fault_pin_out),
    .fault_pin_oe_n(fault_pin_oe_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  host_ctrl_model i_host (.core_clk(core_clk), .arm(arm),
    .clear_go(clear_go), .clear_len(clear_len), .hold_select(hold_select));
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // line must reach lvl after lo and before hi cycles
  task automatic wait_wire(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (fault_wire !== lvl && n < hi)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
    if (n >= hi)
      wrap_up();
    @(posedge core_clk);
  endtask
  task automatic steady(input logic lvl, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      bad += (fault_wire !== lvl);
    end
    chk(bad, 0);
    @(posedge core_clk);
  endtask
  task automatic host_clear(input logic [15:0] len);
    clear_len <= len;
    clear_go <= 1'b1;
    @(posedge core_clk);
    clear_go <= 1'b0;
  endtask
  task automatic s_reset();
    chk(fault_wire, 1'b1);
    rd(8'h04, rv);
    chk(rv, 32'h0);
    wr(8'h0c, 32'hf);
    rd(8'h0c, rv);
    chk(rv, 32'h0);
    cyc(60);
    wr(8'h00, 32'hf);
  endtask
  task automatic s_transparent();
    above_limit <= 1'b1;
    wait_wire(1'b0, 0, 1100);
    wr(8'h04, 32'h1);
    // irq is registered from status and mask, one cycle behind the write
    cyc(1);
    @(negedge core_clk);
    chk(irq, 1'b1);
    @(posedge core_clk);
    above_limit <= 1'b0;
    wait_wire(1'b1, 0, 1100);
    rd(8'h00, rv);
    chk(rv, 32'h3);
    wr(8'h00, 32'h1);
    rd(8'h00, rv);
    chk(rv, 32'h2);
    chk(irq, 1'b0);
    rd(8'h08, rv);
    chk(rv, 32'h4);
  endtask
  task automatic s_counts();
    int need;
    for (int i = 1; i < 3; i++)
    begin
      need = (i == 1) ? 5 : 10;
      response_select <= i[1:0];
      steady(1'b1, 1100);
      above_limit <= 1'b1;
      steady(1'b1, (need - 2) * 500);
      above_limit <= 1'b0;
      steady(1'b1, 1100);
      above_limit <= 1'b1;
      wait_wire(1'b0, (need - 1) * 500, need * 500 + 600);
      above_limit <= 1'b0;
      wait_wire(1'b1, 0, 1100);
    end
    response_select <= 2'h0;
  endtask
  task automatic s_hold();
    arm <= 1'b1;
    cyc(10);
    above_limit <= 1'b1;
    wait_wire(1'b0, 0, 1100);
    host_clear(16'd1100);
    steady(1'b0, 1600);
    above_limit <= 1'b0;
    steady(1'b0, 1600);
    host_clear(16'd300);
    steady(1'b0, 1600);
    host_clear(16'd1100);
    wait_wire(1'b1, 490, 1700);
    arm <= 1'b0;
    cyc(10);
  endtask
  task automatic s_disable();
    above_limit <= 1'b1;
    wait_wire(1'b0, 0, 1100);
    wr(8'h00, 32'hf);
    enable <= 1'b0;
    response_select <= 2'h1;
    steady(1'b0, 900);
    wait_wire(1'b1, 0, 300);
    rd(8'h00, rv);
    chk(rv & 32'h4, 32'h4);
    rd(8'h08, rv);
    chk(rv & 32'hf5, 32'h0);
    enable <= 1'b1;
    wait_wire(1'b0, 2000, 3300);
    above_limit <= 1'b0;
    wait_wire(1'b1, 0, 1100);
  endtask
  initial
  begin
    cyc(12);
    rst <= 1'b0;
    s_reset();
    s_transparent();
    s_counts();
    s_hold();
    s_disable();
    wrap_up();
  end
endmodule // tb
